/* File: rtl/arw_pkg.sv */
// Constants, field layouts and carrier types for the converter result and window registers.
// Assumes a byte-wide CPU register port and a conversion sequencer on the same clock.
// Overview of operation
// - Run-when-halted 0 freezes converter and events in break debug; 1 keeps running.
// - One shared 8-bit read-write staging byte serves every 16-bit register.
// - Conversion value low byte at base offset, high byte at base plus one.
// - A single conversion clamps to 0x3FF above reference and 0x000 below ground.
// - Accumulated result never exceeds 0xFFC0 after at most 64 samples.
// - Raw sample is 10 bits; values and limits compare as unsigned magnitudes.
// - With accumulation, the window check uses the final sum, not single samples.
// - Window low limit is a read-write byte pair at 0x12/0x13, reset zero.
// - Window high limit is a read-write byte pair at 0x14/0x15, reset zero.
// - Duty select resets to 1; 0 means 50 percent, 1 means 25 percent high.
// - Conversion value is read-only and all sixteen bits reset to zero.
// - Window mode codes: 0 off, 1 below, 2 above, 3 inside, 4 outside.
// - Window match flag is set at conversion end when the mode condition holds.
// - Done flag sets on each new value; cleared by writing one or reading value.
package arw_pkg;

  // Register byte offsets.
  localparam logic [4:0] ARW_OFS_FLAGS     = 5'h0b;
  localparam logic [4:0] ARW_OFS_DEBUG_RUN = 5'h0c;
  localparam logic [4:0] ARW_OFS_STAGING   = 5'h0d;
  localparam logic [4:0] ARW_OFS_CONV_LO   = 5'h10;
  localparam logic [4:0] ARW_OFS_CONV_HI   = 5'h11;
  localparam logic [4:0] ARW_OFS_WLOW_LO   = 5'h12;
  localparam logic [4:0] ARW_OFS_WLOW_HI   = 5'h13;
  localparam logic [4:0] ARW_OFS_WHIGH_LO  = 5'h14;
  localparam logic [4:0] ARW_OFS_WHIGH_HI  = 5'h15;
  localparam logic [4:0] ARW_OFS_DUTY_CFG  = 5'h16;

  // Field positions.
  localparam int ARW_BIT_RUN_WHEN_HALTED = 0;
  localparam int ARW_BIT_DUTY_SELECT     = 0;
  localparam int ARW_BIT_DONE_FLAG       = 0;
  localparam int ARW_BIT_MATCH_FLAG      = 1;

  // Reset values.
  localparam logic [7:0]  ARW_RST_STAGING   = 8'h00;
  localparam logic [15:0] ARW_RST_CONV      = 16'h0000;
  localparam logic [15:0] ARW_RST_WLOW      = 16'h0000;
  localparam logic [15:0] ARW_RST_WHIGH     = 16'h0000;
  localparam logic        ARW_RST_DUTY      = 1'b1;
  localparam logic        ARW_RST_RUN_HALT  = 1'b0;

  // Value limits.
  localparam logic [15:0] ARW_SINGLE_MAX = 16'h03ff;
  localparam logic [15:0] ARW_ACCUM_MAX  = 16'hffc0;

  // Window match mode codes.
  localparam logic [2:0] ARW_WIN_NONE    = 3'h0;
  localparam logic [2:0] ARW_WIN_BELOW   = 3'h1;
  localparam logic [2:0] ARW_WIN_ABOVE   = 3'h2;
  localparam logic [2:0] ARW_WIN_INSIDE  = 3'h3;
  localparam logic [2:0] ARW_WIN_OUTSIDE = 3'h4;

  // Finished measurement handed over by the sequencer.
  typedef struct packed {
    logic        valid;
    logic        accumulated;
    logic [15:0] value;
  } arw_sample_s;

  // CPU register access request.
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [4:0] addr;
    logic [7:0] wr_data;
  } arw_bus_s;

endpackage

/* File: rtl/arw_window_cmp.sv */
// Window comparator for the finished conversion value.
// Assumes all inputs are stable registered values on the system clock.
`timescale 1ns/1ps
module arw_window_cmp import arw_pkg::*; (
  input  wire logic [2:0]  window_match_mode,
  input  wire logic [15:0] value,
  input  wire logic [15:0] window_low_limit,
  input  wire logic [15:0] window_high_limit,
  output logic             match
);

  logic below;
  logic above;

  // Unsigned magnitude comparisons; zero is smallest, all ones is full scale.
  assign below = value < window_low_limit;
  assign above = value > window_high_limit;

  // Selects the condition; reserved codes never match.
  always_comb begin
    match = 1'b0;
    case (window_match_mode)
      ARW_WIN_BELOW:   match = below;
      ARW_WIN_ABOVE:   match = above;
      ARW_WIN_INSIDE:  match = (value > window_low_limit) && (value < window_high_limit);
      ARW_WIN_OUTSIDE: match = below || above;
      default:         match = 1'b0;
    endcase
  end

endmodule

/* File: rtl/arw_regs.sv */
// Result, window limit, staging, debug-run and duty registers of the converter.
// Assumes a byte-wide CPU port and a sequencer strobe, both on clk with no crossing.
`timescale 1ns/1ps
module arw_regs import arw_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire arw_bus_s    bus,
  input  wire arw_sample_s sample,
  input  wire logic [2:0]  window_match_mode,
  input  wire logic        cpu_debug_halt,
  output logic [7:0]       rd_data,
  output logic             converter_run,
  output logic             event_accept,
  output logic             clock_duty_select,
  output logic             conversion_done_flag,
  output logic             window_match_flag,
  output logic [15:0]      conversion_value,
  output logic [15:0]      window_low_limit,
  output logic [15:0]      window_high_limit
);

  // Whole register state of the block.
  typedef struct packed {
    logic        run_when_halted;
    logic [7:0]  staging;
    logic [15:0] conv;
    logic [15:0] wlow;
    logic [15:0] whigh;
    logic        duty;
    logic        done;
    logic        match;
    logic        run;
    logic [7:0]  rdat;
  } arw_state_s;

  arw_state_s  st_q;
  arw_state_s  st_d;
  logic [15:0] clamped;
  logic        cmp_match;
  logic        frozen;
  logic        take;
  logic        wr;
  logic        rd;

  assign wr = bus.wr_en;
  assign rd = bus.rd_en;

  // A halted CPU freezes the converter unless run-when-halted is set.
  assign frozen = cpu_debug_halt && !st_q.run_when_halted;

  // Completion strobes are ignored while frozen, so no strobe loads the value or sets a flag.
  assign take = sample.valid && !frozen;

  // Clamp a single conversion to ten bits and a sum to its largest legal total.
  always_comb begin
    clamped = sample.value;
    if (sample.accumulated) begin
      if (sample.value > ARW_ACCUM_MAX) begin
        clamped = ARW_ACCUM_MAX;
      end
    end else if (sample.value > ARW_SINGLE_MAX) begin
      clamped = ARW_SINGLE_MAX;
    end
  end

  // The comparator sees the incoming final value, which for accumulation is the sum.
  arw_window_cmp u_cmp (
    .window_match_mode (window_match_mode),
    .value             (clamped),
    .window_low_limit  (st_q.wlow),
    .window_high_limit (st_q.whigh),
    .match             (cmp_match)
  );

  // Next-state logic: register writes, reads with staging side effects, and flag events.
  always_comb begin
    st_d      = st_q;
    st_d.rdat = 8'h00;
    st_d.run  = !frozen;

    // Register writes; the conversion value ignores all writes.
    if (wr) begin
      if (bus.addr == ARW_OFS_DEBUG_RUN) begin
        st_d.run_when_halted = bus.wr_data[ARW_BIT_RUN_WHEN_HALTED];
      end else if (bus.addr == ARW_OFS_STAGING) begin
        st_d.staging = bus.wr_data;
      end else if (bus.addr == ARW_OFS_WLOW_LO || bus.addr == ARW_OFS_WHIGH_LO) begin
        st_d.staging = bus.wr_data;
      end else if (bus.addr == ARW_OFS_WLOW_HI) begin
        st_d.wlow = {bus.wr_data, st_q.staging};
      end else if (bus.addr == ARW_OFS_WHIGH_HI) begin
        st_d.whigh = {bus.wr_data, st_q.staging};
      end else if (bus.addr == ARW_OFS_DUTY_CFG) begin
        st_d.duty = bus.wr_data[ARW_BIT_DUTY_SELECT];
      end else if (bus.addr == ARW_OFS_FLAGS) begin
        // Writing one clears a flag, writing zero leaves it.
        if (bus.wr_data[ARW_BIT_DONE_FLAG]) begin
          st_d.done = 1'b0;
        end
        if (bus.wr_data[ARW_BIT_MATCH_FLAG]) begin
          st_d.match = 1'b0;
        end
      end
    end

    // Register reads; unmapped offsets and reserved bits return zero.
    if (rd) begin
      if (bus.addr == ARW_OFS_FLAGS) begin
        st_d.rdat[ARW_BIT_DONE_FLAG]  = st_q.done;
        st_d.rdat[ARW_BIT_MATCH_FLAG] = st_q.match;
      end else if (bus.addr == ARW_OFS_DEBUG_RUN) begin
        st_d.rdat[ARW_BIT_RUN_WHEN_HALTED] = st_q.run_when_halted;
      end else if (bus.addr == ARW_OFS_STAGING) begin
        st_d.rdat = st_q.staging;
      end else if (bus.addr == ARW_OFS_CONV_LO) begin
        st_d.rdat    = st_q.conv[7:0];
        st_d.staging = st_q.conv[15:8];
        st_d.done    = 1'b0;
        st_d.match   = 1'b0;
      end else if (bus.addr == ARW_OFS_CONV_HI) begin
        st_d.rdat = st_q.staging;
      end else if (bus.addr == ARW_OFS_WLOW_LO) begin
        st_d.rdat    = st_q.wlow[7:0];
        st_d.staging = st_q.wlow[15:8];
      end else if (bus.addr == ARW_OFS_WLOW_HI) begin
        st_d.rdat = st_q.staging;
      end else if (bus.addr == ARW_OFS_WHIGH_LO) begin
        st_d.rdat    = st_q.whigh[7:0];
        st_d.staging = st_q.whigh[15:8];
      end else if (bus.addr == ARW_OFS_WHIGH_HI) begin
        st_d.rdat = st_q.staging;
      end else if (bus.addr == ARW_OFS_DUTY_CFG) begin
        st_d.rdat[ARW_BIT_DUTY_SELECT] = st_q.duty;
      end
    end

    // A finished measurement loads the value, sets done and, on a comparator match, the match flag; set wins over any clear.
    if (take) begin
      st_d.conv = clamped;
      st_d.done = 1'b1;
      if (cmp_match) begin
        st_d.match = 1'b1;
      end
    end
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q.run_when_halted <= ARW_RST_RUN_HALT;
      st_q.staging         <= ARW_RST_STAGING;
      st_q.conv            <= ARW_RST_CONV;
      st_q.wlow            <= ARW_RST_WLOW;
      st_q.whigh           <= ARW_RST_WHIGH;
      st_q.duty            <= ARW_RST_DUTY;
      st_q.done            <= 1'b0;
      st_q.match           <= 1'b0;
      st_q.run             <= 1'b1;
      st_q.rdat            <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register.
  assign rd_data              = st_q.rdat;
  assign converter_run        = st_q.run;
  assign event_accept         = st_q.run;
  assign clock_duty_select    = st_q.duty;
  assign conversion_done_flag = st_q.done;
  assign window_match_flag    = st_q.match;
  assign conversion_value     = st_q.conv;
  assign window_low_limit     = st_q.wlow;
  assign window_high_limit    = st_q.whigh;

endmodule

/* File: bench/arw_cpu_model.sv */
// CPU master model for the converter register port.
// Assumes requests are taken on rising clk and read data stands one cycle later.
`timescale 1ns/1ps
module arw_cpu_model import arw_pkg::*; (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output arw_bus_s        bus
);
  initial bus = '0;
  // A write stands for one taking edge; idle address is inverted so stale use shows.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '{1'b0, 1'b0, ~a, ~d};
    @(posedge clk);
  endtask
  // A read takes its answer just after the edge that takes it, once the bus has gone idle.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus <= '{1'b0, 1'b0, ~a, 8'h5a};
    #1;
    d = rd_data;
    @(posedge clk);
  endtask
endmodule

/* File: bench/arw_regs_props.sv */
// Checker for the result and window registers.
// Assumes it is bound onto arw_regs and sees only its ports.
`timescale 1ns/1ps
module arw_regs_props import arw_pkg::*; (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire arw_bus_s    bus,
  input wire arw_sample_s sample,
  input wire logic [2:0]  window_match_mode,
  input wire logic        cpu_debug_halt,
  input wire logic        converter_run,
  input wire logic        event_accept,
  input wire logic        conversion_done_flag,
  input wire logic        window_match_flag,
  input wire logic [15:0] conversion_value,
  input wire logic [15:0] window_low_limit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A strobe outside any halt must always be taken.
  logic take;
  assign take = sample.valid && !cpu_debug_halt;
  a_run_no_halt: assert property (!cpu_debug_halt |=> converter_run)
    else $error("converter frozen without halt");
  a_event_same: assert property (event_accept == converter_run)
    else $error("event accept differs from run");
  a_single_clamp: assert property (take && !sample.accumulated && sample.value > 16'h03ff
    |=> conversion_value == 16'h03ff) else $error("single value not clamped");
  a_accum_clamp: assert property (take && sample.accumulated && sample.value > 16'hffc0
    |=> conversion_value == 16'hffc0) else $error("sum not clamped");
  a_done_set: assert property (take |=> conversion_done_flag)
    else $error("done flag not set");
  a_read_clear: assert property (bus.rd_en && bus.addr == 5'h10 && !sample.valid
    |=> !conversion_done_flag && !window_match_flag) else $error("flags kept after read");
  a_value_ro: assert property (!sample.valid |=> $stable(conversion_value))
    else $error("value changed without sample");
  a_low_commit: assert property (bus.wr_en && bus.addr == 5'h13
    |=> window_low_limit[15:8] == $past(bus.wr_data)) else $error("low limit not committed");
  a_match_below: assert property (take && window_match_mode == 3'h1 &&
    !sample.accumulated && sample.value < window_low_limit |=> window_match_flag)
    else $error("below match missed");
endmodule
bind arw_regs arw_regs_props i_props (.*);

/* File: bench/tb.sv */
// Self-checking bench for the result and window registers.
// Assumes arw_cpu_model as CPU and the bound checker arw_regs_props.
`timescale 1ns/1ps
module tb import arw_pkg::*; ;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  arw_bus_s    bus;
  arw_sample_s sample = '0;
  logic [2:0]  mode = 3'h0;
  logic        halt = 1'b0;
  logic [7:0]  rd_data;
  logic        run, evt, duty, done, match;
  logic [15:0] cval, wlo, whi;
  logic [7:0]  d;
  logic [0:29] tbl = 30'b00000_10000_00001_00100_10001_00000;
  logic [15:0] vals [5] = '{16'h0080, 16'h0100, 16'h0180, 16'h0200, 16'h0280};
  int          fails = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  arw_cpu_model i_arw_cpu_model (.clk(clk), .rd_data(rd_data), .bus(bus));
  arw_regs i_arw_regs (.clk(clk), .rst_n(rst_n), .bus(bus), .sample(sample),
    .window_match_mode(mode), .cpu_debug_halt(halt), .rd_data(rd_data),
    .converter_run(run), .event_accept(evt), .clock_duty_select(duty),
    .conversion_done_flag(done), .window_match_flag(match), .conversion_value(cval),
    .window_low_limit(wlo), .window_high_limit(whi));
  // Comparison, bus and strobe helpers; the bus and strobe ones end just after a clock edge.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_arw_cpu_model.wr(a, v);
    #1;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    i_arw_cpu_model.rd(a, d);
    #1;
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic smp(input logic acc, input logic [15:0] v);
    sample <= '{1'b1, acc, v};
    @(posedge clk);
    sample <= '{1'b0, 1'b0, ~v};
    #1;
  endtask
  // Reset values, then limits staged and committed through the shared byte.
  task automatic t_regs;
    chk(16'(duty), 16'h0001);
    rdc(5'h16, 8'h01);
    rdc(5'h0c, 8'h00);
    for (int a = 13; a < 22; a++) rdc(5'(a), 8'h00);
    wr(5'h12, 8'h00);
    wr(5'h13, 8'h01);
    chk(wlo, 16'h0100);
    wr(5'h14, 8'h00);
    chk(whi, 16'h0000);
    wr(5'h15, 8'h02);
    chk(whi, 16'h0200);
    rdc(5'h14, 8'h00);
    rdc(5'h0d, 8'h02);
    wr(5'h0d, 8'h77);
    rdc(5'h13, 8'h77);
    wr(5'h10, 8'hff);
    chk(cval, 16'h0000);
  endtask
  // Clamping, byte order and both ways of clearing the done flag.
  task automatic t_conv;
    smp(1'b0, 16'h1234);
    chk(cval, 16'h03ff);
    rdc(5'h0b, 8'h01);
    rdc(5'h10, 8'hff);
    rdc(5'h0b, 8'h00);
    chk(16'(done), 16'h0000);
    rdc(5'h11, 8'h03);
    smp(1'b1, 16'hffff);
    chk(cval, 16'hffc0);
    wr(5'h0b, 8'h00);
    chk(16'(done), 16'h0001);
    wr(5'h0b, 8'h03);
    chk(16'(done), 16'h0000);
  endtask
  // Mode codes 0 to 5 against values at and around both limits.
  task automatic t_modes;
    for (int m = 0; m < 6; m++) begin
      for (int i = 0; i < 5; i++) begin
        mode <= 3'(m);
        wr(5'h0b, 8'h03);
        smp(i[0], vals[i]);
        chk(16'(match), 16'(tbl[m * 5 + i]));
      end
    end
  endtask
  // Debug halt freezes converter and events until run-when-halted is set; then duty select.
  task automatic t_debug;
    halt <= 1'b1;
    wr(5'h0b, 8'h03);
    chk(16'(run), 16'h0000);
    chk(16'(evt), 16'h0000);
    smp(1'b0, 16'h0055);
    chk(16'(done), 16'h0000);
    wr(5'h0c, 8'h01);
    chk(16'(evt), 16'h0001);
    smp(1'b0, 16'h0055);
    chk(cval, 16'h0055);
    halt <= 1'b0;
    wr(5'h16, 8'h00);
    chk(16'(duty), 16'h0000);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reset for three cycles, run the scenarios, and cut any hang short.
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_regs();
    t_conv();
    t_modes();
    t_debug();
    report_and_stop();
  end
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
endmodule
